//--- hdl/pcg_regs.svh
// constants for the peripheral clock gate block: offsets, fields, resets
// assumes byte addresses on an 8-bit register port and 32-bit data
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// register byte addresses
`define PCG_GATE0_ADDR 8'h24
`define PCG_BLOCKED_ADDR 8'h28
`define PCG_COUNT_ADDR 8'h2C

// gate register layout
`define PCG_GATE_RESET 32'hFFFF_F800
`define PCG_RW_MASK 32'h1087_A000
`define PCG_RO_ONES 32'hEF78_5800

// gating bit positions, one per peripheral
`define PCG_BIT_SB0 5'h0D
`define PCG_BIT_SB1 5'h1C
`define PCG_BIT_CONV 5'h17
`define PCG_BIT_TIMER_ZERO_CLOCK_OFF 5'h0F
`define PCG_BIT_TIMER_ONE_CLOCK_OFF 5'h10
`define PCG_BIT_TIMER_TWO_CLOCK_OFF 5'h11
`define PCG_BIT_TIMER_THREE_CLOCK_OFF 5'h12

// peripheral slot numbers inside the gated vector
`define PCG_SLOT_SB0 3'h0
`define PCG_SLOT_SB1 3'h1
`define PCG_SLOT_CONV 3'h2
`define PCG_SLOT_TIMER_ZERO_CLOCK_OFF 3'h3
`define PCG_SLOT_TIMER_ONE_CLOCK_OFF 3'h4
`define PCG_SLOT_TIMER_TWO_CLOCK_OFF 3'h5
`define PCG_SLOT_TIMER_THREE_CLOCK_OFF 3'h6

// misc values
`define PCG_ZERO32 32'h0000_0000
`define PCG_ONE32 32'h0000_0001
`define PCG_NUM_PERIPH 7

`endif

//--- hdl/pcg_pkg.sv
// types shared by the peripheral clock gate block
// assumes the constants header is compiled alongside
package pcg_pkg;

    // one bit per gated peripheral
    typedef logic [6:0] pcg_periph_vec_t;

    // state of the top level register file
    typedef struct packed {
        logic [31:0] gate;
        logic [6:0] blocked;
        logic [31:0] count;
        logic [31:0] rdata;
    } pcg_top_state_t;

    // state of one glitch-free gate cell
    typedef struct packed {
        logic en;
    } pcg_cell_state_t;

    // state of one access filter
    typedef struct packed {
        logic blocked;
    } pcg_filt_state_t;

endpackage : pcg_pkg

//--- hdl/pcg_clock_gate_cell.sv
// glitch-free clock gate for one peripheral
// assumes clock_off_in is launched from rising-edge flops of core_clk_in
`timescale 1ns/1ps
module pcg_clock_gate_cell (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic clock_off_in,
    output logic gated_clk_out
);
    import pcg_pkg::*;

    pcg_cell_state_t s_q;
    pcg_cell_state_t s_d;

    // enable only moves while the clock is low, so no runt pulse escapes
    always_comb begin
        s_d = s_q;
        s_d.en = ~clock_off_in;
        if (!nrst_in) begin
            s_d.en = 1'b0; // reset state is clock off
        end
    end

    // falling edge retime of the enable
    always_ff @(negedge core_clk_in) begin
        s_q <= s_d;
    end

    assign gated_clk_out = core_clk_in & s_q.en;
endmodule : pcg_clock_gate_cell

//--- hdl/pcg_access_filter.sv
// bus access filter in front of one gated peripheral
// assumes the upstream decoder raises sel with a one-cycle strobe
`timescale 1ns/1ps
module pcg_access_filter (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic clock_off_in,
    input wire logic sel_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic wr_out,
    output logic rd_out,
    output logic blocked_out
);
    import pcg_pkg::*;

    pcg_filt_state_t s_q;
    pcg_filt_state_t s_d;

    // strobes pass only to a running peripheral; a stopped one never
    // sees them, so its registers keep whatever they held
    assign wr_out = sel_in & wr_in & ~clock_off_in;
    assign rd_out = sel_in & rd_in & ~clock_off_in;

    // refused access is reported one cycle later
    always_comb begin
        s_d = s_q;
        s_d.blocked = sel_in & (wr_in | rd_in) & clock_off_in;
        if (!nrst_in) begin
            s_d.blocked = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        s_q <= s_d;
    end

    assign blocked_out = s_q.blocked;
endmodule : pcg_access_filter

//--- hdl/pcg_top.sv
// peripheral clock gate, upper 21 bits of the clock-disable register
// assumes one clock, synchronous active-low reset, a plain register port
// and an upstream bus decoder giving a select per gated peripheral
//
// How it works
// - bit 1 stops peripheral clock, 0 runs
// - accesses to stopped peripheral are dropped
// - stopped peripheral keeps its register contents
// - bit 28 gates serial bus one, reset 1
// - bit 13 gates serial bus zero, reset 1
// - bit 23 converter, 15-18 timers, reset 1
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pcg_regs.svh"
module pcg_top #(
    parameter int unsigned BLOCK_CNT_W = 16
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire pcg_pkg::pcg_periph_vec_t periph_sel_in,
    input wire logic periph_wr_in,
    input wire logic periph_rd_in,
    output pcg_pkg::pcg_periph_vec_t periph_wr_out,
    output pcg_pkg::pcg_periph_vec_t periph_rd_out,
    output pcg_pkg::pcg_periph_vec_t periph_clk_out,
    output logic serial_bus0_clock_off_out,
    output logic serial_bus1_clock_off_out,
    output logic converter_clock_off_out,
    output logic timer_zero_clock_off_out,
    output logic timer_one_clock_off_out,
    output logic timer_two_clock_off_out,
    output logic timer_three_clock_off_out
);
    import pcg_pkg::*;

    // the count register is 32 bits wide; wider counters cannot be read
    if (BLOCK_CNT_W < 1 || BLOCK_CNT_W > 32) begin : g_bad_cnt_w
        $error("BLOCK_CNT_W must lie between 1 and 32");
    end

    // saturation value of the refused-access counter
    localparam logic [31:0] CNT_MAX =
        (BLOCK_CNT_W == 32) ? 32'hFFFF_FFFF
                            : ((`PCG_ONE32 << BLOCK_CNT_W) - `PCG_ONE32);

    pcg_top_state_t s_q;
    pcg_top_state_t s_d;

    pcg_periph_vec_t clock_off;
    pcg_periph_vec_t blocked_evt;

    // gating bit position of each peripheral slot
    function automatic logic [4:0] gate_bit(input logic [2:0] slot);
        logic [4:0] pos;
        pos = `PCG_BIT_SB0;
        unique case (slot)
            `PCG_SLOT_SB0: pos = `PCG_BIT_SB0;
            `PCG_SLOT_SB1: pos = `PCG_BIT_SB1;
            `PCG_SLOT_CONV: pos = `PCG_BIT_CONV;
            `PCG_SLOT_TIMER_ZERO_CLOCK_OFF: pos = `PCG_BIT_TIMER_ZERO_CLOCK_OFF;
            `PCG_SLOT_TIMER_ONE_CLOCK_OFF: pos = `PCG_BIT_TIMER_ONE_CLOCK_OFF;
            `PCG_SLOT_TIMER_TWO_CLOCK_OFF: pos = `PCG_BIT_TIMER_TWO_CLOCK_OFF;
            `PCG_SLOT_TIMER_THREE_CLOCK_OFF: pos = `PCG_BIT_TIMER_THREE_CLOCK_OFF;
            default: pos = `PCG_BIT_SB0; // slot 7 does not exist
        endcase
        return pos;
    endfunction : gate_bit

    // visible value of the gate register: writable bits from the flops,
    // read-only bits forced high, bits below the window read zero
    function automatic logic [31:0] gate_view(input logic [31:0] g);
        return (g & `PCG_RW_MASK) | `PCG_RO_ONES;
    endfunction : gate_view

    // address decode used by both the write and the read path
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    // clock-off level of every slot, straight from the gate register
    always_comb begin
        clock_off = '0;
        for (int i = 0; i < `PCG_NUM_PERIPH; i++) begin
            clock_off[i] = s_q.gate[gate_bit(3'(i))];
        end
    end

    // one gate cell and one access filter per peripheral
    for (genvar g = 0; g < `PCG_NUM_PERIPH; g++) begin : g_periph
        pcg_clock_gate_cell u_cell (
            .core_clk_in(core_clk_in),
            .nrst_in(nrst_in),
            .clock_off_in(clock_off[g]),
            .gated_clk_out(periph_clk_out[g])
        );

        pcg_access_filter u_filt (
            .core_clk_in(core_clk_in),
            .nrst_in(nrst_in),
            .clock_off_in(clock_off[g]),
            .sel_in(periph_sel_in[g]),
            .wr_in(periph_wr_in),
            .rd_in(periph_rd_in),
            .wr_out(periph_wr_out[g]),
            .rd_out(periph_rd_out[g]),
            .blocked_out(blocked_evt[g])
        );
    end

    // register file, refused-access flags and counter
    always_comb begin
        s_d = s_q;
        s_d.rdata = `PCG_ZERO32; // read data stands one cycle only

        // gate register: only the writable bits take the write
        if (reg_wr_in && hit(reg_addr_in, `PCG_GATE0_ADDR)) begin
            s_d.gate = (s_q.gate & ~`PCG_RW_MASK)
                     | (reg_wdata_in & `PCG_RW_MASK);
        end

        // refused-access flags: write one to clear, a new event wins
        if (reg_wr_in && hit(reg_addr_in, `PCG_BLOCKED_ADDR)) begin
            s_d.blocked = s_q.blocked & ~reg_wdata_in[6:0];
        end
        s_d.blocked = s_d.blocked | blocked_evt;

        // counter: any write clears it, an event in the same cycle
        // still counts so none is lost; it sticks at its top value
        if (reg_wr_in && hit(reg_addr_in, `PCG_COUNT_ADDR)) begin
            s_d.count = `PCG_ZERO32;
        end
        if (|blocked_evt && s_d.count != CNT_MAX) begin
            s_d.count = s_d.count + `PCG_ONE32;
        end

        // read path: unmapped addresses answer zero
        if (reg_rd_in) begin
            unique case (1'b1)
                hit(reg_addr_in, `PCG_GATE0_ADDR):
                    s_d.rdata = gate_view(s_q.gate);
                hit(reg_addr_in, `PCG_BLOCKED_ADDR):
                    s_d.rdata = {25'h0000000, s_q.blocked};
                hit(reg_addr_in, `PCG_COUNT_ADDR):
                    s_d.rdata = s_q.count;
                default:
                    s_d.rdata = `PCG_ZERO32;
            endcase
        end

        // every peripheral starts with its clock stopped
        if (!nrst_in) begin
            s_d.gate = `PCG_GATE_RESET;
            s_d.blocked = '0;
            s_d.count = `PCG_ZERO32;
            s_d.rdata = `PCG_ZERO32;
        end
    end

    // single state register
    always_ff @(posedge core_clk_in) begin
        s_q <= s_d;
    end

    assign reg_rdata_out = s_q.rdata;

    // per-peripheral status levels, all from the gate register flops
    assign serial_bus0_clock_off_out = clock_off[`PCG_SLOT_SB0];
    assign serial_bus1_clock_off_out = clock_off[`PCG_SLOT_SB1];
    assign converter_clock_off_out = clock_off[`PCG_SLOT_CONV];
    assign timer_zero_clock_off_out = clock_off[`PCG_SLOT_TIMER_ZERO_CLOCK_OFF];
    assign timer_one_clock_off_out = clock_off[`PCG_SLOT_TIMER_ONE_CLOCK_OFF];
    assign timer_two_clock_off_out = clock_off[`PCG_SLOT_TIMER_TWO_CLOCK_OFF];
    assign timer_three_clock_off_out = clock_off[`PCG_SLOT_TIMER_THREE_CLOCK_OFF];
endmodule : pcg_top

//--- bench/pcg_top_sva.sv
// checker for the clock gate top: gate bits, strobe filter, read image
// assumes a bind from the testbench file and the constants header
`timescale 1ns/1ps
`include "pcg_regs.svh"
module pcg_top_sva #(
    parameter int unsigned BLOCK_CNT_W = 16
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire pcg_pkg::pcg_periph_vec_t periph_sel_in,
    input wire logic periph_wr_in,
    input wire logic periph_rd_in,
    input wire pcg_pkg::pcg_periph_vec_t periph_wr_out,
    input wire pcg_pkg::pcg_periph_vec_t periph_rd_out,
    input wire pcg_pkg::pcg_periph_vec_t periph_clk_out,
    input wire logic serial_bus0_clock_off_out,
    input wire logic serial_bus1_clock_off_out,
    input wire logic converter_clock_off_out,
    input wire logic timer_zero_clock_off_out,
    input wire logic timer_one_clock_off_out,
    input wire logic timer_two_clock_off_out,
    input wire logic timer_three_clock_off_out
);
    import pcg_pkg::*;
    logic [6:0] off;
    logic [6:0] wmap;
    logic [31:0] img;
    // slot order of the gated vector, and the register image it implies
    assign off = {timer_three_clock_off_out, timer_two_clock_off_out,
        timer_one_clock_off_out, timer_zero_clock_off_out,
        converter_clock_off_out, serial_bus1_clock_off_out,
        serial_bus0_clock_off_out};
    assign wmap = {reg_wdata_in[18:15], reg_wdata_in[23], reg_wdata_in[28],
        reg_wdata_in[13]};
    assign img = {3'h7, off[1], 4'hF, off[2], 4'hF, off[6:3], 1'h1, off[0],
        2'h3, 11'h000};
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence gate_wr;
        reg_wr_in && reg_addr_in == `PCG_GATE0_ADDR;
    endsequence
    a_reset_off: assert property (
        $rose(nrst_in) |-> off == 7'h7F) else $error("gate not reset to off");
    a_gate_write: assert property (
        gate_wr |=> off == $past(wmap)) else $error("gate bits not written");
    a_gate_hold: assert property (
        !(reg_wr_in && reg_addr_in == `PCG_GATE0_ADDR) |=> $stable(off))
        else $error("gate bits moved");
    a_read_map: assert property (
        reg_rd_in && reg_addr_in == `PCG_GATE0_ADDR |=>
        reg_rdata_out == $past(img)) else $error("gate read image wrong");
    a_wr_filter: assert property (
        periph_wr_out == (periph_sel_in & {7{periph_wr_in}} & ~off))
        else $error("write strobe filter wrong");
    a_rd_filter: assert property (
        periph_rd_out == (periph_sel_in & {7{periph_rd_in}} & ~off))
        else $error("read strobe filter wrong");
    // sampled at the end of the high phase, the gated clock shows the retimed enable
    a_clk_stop: assert property (
        @(negedge core_clk_in) periph_clk_out == ~$past(off))
        else $error("gated clock disagrees with gate bit");
endmodule : pcg_top_sva

//--- bench/testbench.sv
// self-checking bench for the clock gate top
// assumes the constants header, package and checker are compiled first
`timescale 1ns/1ps
`include "pcg_regs.svh"
module testbench;
    import pcg_pkg::*;
    logic core_clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic periph_wr_in = 1'h0;
    logic periph_rd_in = 1'h0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out;
    logic [31:0] v;
    pcg_periph_vec_t periph_sel_in = 7'h7F;
    pcg_periph_vec_t periph_wr_out, periph_rd_out, periph_clk_out;
    logic [6:0] off;
    int bits[7] = '{13, 28, 23, 15, 16, 17, 18};
    int bad_count = 0;
    int num_checks = 0;
    pcg_top u_pcg_top (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .periph_sel_in, .periph_wr_in,
        .periph_rd_in, .periph_wr_out, .periph_rd_out, .periph_clk_out,
        .serial_bus0_clock_off_out(off[0]), .serial_bus1_clock_off_out(off[1]),
        .converter_clock_off_out(off[2]), .timer_zero_clock_off_out(off[3]),
        .timer_one_clock_off_out(off[4]), .timer_two_clock_off_out(off[5]),
        .timer_three_clock_off_out(off[6]));
    // 100 MHz system clock
    always #5 core_clk_in = ~core_clk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'h0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'h0;
        #1 v = reg_rdata_out;
    endtask : rd
    // strobes on the selected slots: only running slots may pass strobes and clock
    task automatic ptest(input logic [6:0] exp);
        @(posedge core_clk_in);
        periph_wr_in <= 1'h1;
        #1 chk(32'(periph_wr_out), 32'(exp));
        @(posedge core_clk_in);
        periph_wr_in <= 1'h0;
        periph_rd_in <= 1'h1;
        #1 chk(32'(periph_rd_out), 32'(exp));
        @(posedge core_clk_in);
        periph_rd_in <= 1'h0;
        #2 chk(32'(periph_clk_out), 32'(exp));
    endtask : ptest
    task automatic final_report;
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // main sequence: reset, then walk each gate bit alone
    initial begin
        repeat (8) @(posedge core_clk_in);
        nrst_in <= 1'h1;
        rd(`PCG_GATE0_ADDR);
        chk(v, 32'hFFFF_F800);
        ptest(7'h00);
        wr(`PCG_GATE0_ADDR, 32'h0000_0000);
        rd(`PCG_GATE0_ADDR);
        chk(v, 32'hEF78_5800);
        ptest(7'h7F);
        for (int i = 0; i < 7; i++) begin
            wr(`PCG_GATE0_ADDR, 32'h1 << bits[i]);
            rd(`PCG_GATE0_ADDR);
            chk(v, 32'hEF78_5800 | (32'h1 << bits[i]));
            chk(32'(off), 32'h1 << i);
            ptest(~(7'h01 << i));
        end
        wr(`PCG_GATE0_ADDR, 32'hFFFF_FFFF);
        rd(`PCG_GATE0_ADDR);
        chk(v, 32'hFFFF_F800);
        rd(8'h30);
        chk(v, 32'h0000_0000);
        // refused accesses to one stopped slot set its flag, count per cycle
        wr(`PCG_BLOCKED_ADDR, 32'h0000_007F);
        wr(`PCG_COUNT_ADDR, 32'h0000_0000);
        periph_sel_in <= 7'h04;
        ptest(7'h00);
        rd(`PCG_BLOCKED_ADDR);
        chk(v, 32'h0000_0004);
        rd(`PCG_COUNT_ADDR);
        chk(v, 32'h0000_0002);
        wr(`PCG_BLOCKED_ADDR, 32'h0000_0004);
        wr(`PCG_COUNT_ADDR, 32'h0000_0000);
        periph_sel_in <= 7'h7F;
        wr(`PCG_GATE0_ADDR, 32'h0000_0000);
        ptest(7'h7F);
        rd(`PCG_BLOCKED_ADDR);
        chk(v, 32'h0000_0000);
        rd(`PCG_COUNT_ADDR);
        chk(v, 32'h0000_0000);
        // a second reset mid-run stops every clock again
        @(posedge core_clk_in);
        nrst_in <= 1'h0;
        repeat (2) @(posedge core_clk_in);
        nrst_in <= 1'h1;
        rd(`PCG_GATE0_ADDR);
        chk(v, 32'hFFFF_F800);
        ptest(7'h00);
        final_report();
    end
    // watchdog, far beyond the roughly 110 cycles the tests need
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
endmodule : testbench
bind pcg_top pcg_top_sva #(.BLOCK_CNT_W(BLOCK_CNT_W)) u_pcg_top_sva (
    .core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .periph_sel_in, .periph_wr_in, .periph_rd_in,
    .periph_wr_out, .periph_rd_out, .periph_clk_out,
    .serial_bus0_clock_off_out, .serial_bus1_clock_off_out,
    .converter_clock_off_out, .timer_zero_clock_off_out,
    .timer_one_clock_off_out, .timer_two_clock_off_out,
    .timer_three_clock_off_out);
